// ---- e1bc_map.vh ----
/*
 * address map, field positions and reset values for the e1 receive
 * block error counter bank.
 * assumes an 8-bit microprocessor port with a 16-bit address whose top
 * nibble selects the channel and whose low 12 bits select the register.
 */
`ifndef E1BC_MAP_VH
`define E1BC_MAP_VH

// address split: channel nibble over a 12-bit register offset
`define E1BC_ADDR_W 16
`define E1BC_CH_MSB 15
`define E1BC_CH_LSB 12
`define E1BC_OFS_MSB 11
`define E1BC_OFS_LSB 0
`define E1BC_OFS_W 12

// register offsets within one channel
`define E1BC_SYNC_BIT_ERROR_COUNT_HIGH 12'h905
`define E1BC_SYNC_BIT_ERROR_COUNT_LOW 12'h906
`define E1BC_FAR_END_BLOCK_ERROR_COUNT_HIGH 12'h907
`define E1BC_FAR_END_BLOCK_ERROR_COUNT_LOW 12'h908

// counter layout
`define E1BC_CNT_W 16
`define E1BC_BYTE_W 8
`define E1BC_HI_MSB 15
`define E1BC_HI_LSB 8
`define E1BC_LO_MSB 7
`define E1BC_LO_LSB 0

// reset and clear values
`define E1BC_CNT_RESET 16'h0000
`define E1BC_CNT_ONE 16'h0001
`define E1BC_CNT_MAX 16'hFFFF
`define E1BC_BYTE_RESET 8'h00
`define E1BC_UNMAPPED_DATA 8'h00

`endif

// ---- e1bc_err_counter.v ----
/*
 * one 16-bit clear-on-read error counter with a lower-byte snapshot.
 * assumes inc, rd_high and rd_low come from logic on ref_clk and that
 * rd_high and rd_low are never high in the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none
`include "e1bc_map.vh"

module e1bc_err_counter (
    input wire ref_clk,
    input wire resetn,
    input wire inc,
    input wire rd_high,
    input wire rd_low,
    output wire [`E1BC_CNT_W-1:0] live_count,
    output wire [`E1BC_BYTE_W-1:0] low_hold,
    output wire hold_valid
);

    reg [`E1BC_CNT_W-1:0] count_reg;
    reg [`E1BC_CNT_W-1:0] count_next;
    reg [`E1BC_BYTE_W-1:0] hold_reg;
    reg [`E1BC_BYTE_W-1:0] hold_next;
    reg hold_valid_reg;
    reg hold_valid_next;

    // next count: an event in the clearing cycle is kept, never lost
    always @* begin
        count_next = count_reg;
        hold_next = hold_reg;
        hold_valid_next = hold_valid_reg;
        if (rd_high) begin
            hold_next = count_reg[`E1BC_LO_MSB:`E1BC_LO_LSB];
            hold_valid_next = 1'b1;
            count_next = inc ? `E1BC_CNT_ONE : `E1BC_CNT_RESET;
        end else if (rd_low) begin
            hold_valid_next = 1'b0;
            if (!hold_valid_reg) begin
                // low read without a prior high read: clear just what was shown
                count_next = {count_reg[`E1BC_HI_MSB:`E1BC_HI_LSB], `E1BC_BYTE_RESET};
                if (inc) begin
                    count_next = count_next + `E1BC_CNT_ONE;
                end
            end else if (inc && count_reg != `E1BC_CNT_MAX) begin
                count_next = count_reg + `E1BC_CNT_ONE;
            end
        end else if (inc && count_reg != `E1BC_CNT_MAX) begin
            // saturate rather than wrap so a long gap never reads small
            count_next = count_reg + `E1BC_CNT_ONE;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            count_reg <= `E1BC_CNT_RESET;
            hold_reg <= `E1BC_BYTE_RESET;
            hold_valid_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            hold_reg <= hold_next;
            hold_valid_reg <= hold_valid_next;
        end
    end

    assign live_count = count_reg;
    assign low_hold = hold_reg;
    assign hold_valid = hold_valid_reg;

endmodule

`default_nettype wire

// ---- e1bc_rx_block_error_counters.v ----
/*
 * per-channel receive crc-4 sync-bit error and far-end block error
 * counters, read over the framer's 8-bit microprocessor port.
 * the counters themselves live in e1bc_err_counter, two per channel.
 * each channel holds two 16-bit clear-on-read counters, each seen as
 * an upper byte and a lower byte at adjacent offsets.
 * an upper-byte read returns bits 15 to 8, parks bits 7 to 0 in a
 * snapshot and restarts the live count, so the lower-byte read that
 * follows returns a value coherent with the upper byte.
 * a lower-byte read with no snapshot pending returns the live low byte
 * and clears only that byte; the upper byte is kept for a later read.
 * counts saturate at all ones instead of wrapping, so a neglected
 * counter never reads back as a small number.
 * an error that arrives in the clearing cycle is kept as a count of one.
 * reads of an unknown offset, or of a channel at or above NUM_CH, return
 * zero with the unmapped flag set and touch no counter.
 * no interrupt and no write path; every register is read-only.
 * read data, the answer pulse and the unmapped flag all come from
 * flip-flops; the data and the flag hold until the next read is taken.
 * assumes the receive framer runs on ref_clk and delivers one-cycle
 * event strobes and sync-loss levels per channel; the host port is
 * synchronous to ref_clk with a one-cycle read strobe.
 * assumes the framer has already qualified the e-bit strobe for crc-4
 * multiframe mode; this block only gates it with the fas and crc-4 sync-loss levels.
 * assumes NUM_CH is at most 16, the reach of the channel nibble.
 */
`timescale 1ns/10ps
`default_nettype none
`include "e1bc_map.vh"

module e1bc_rx_block_error_counters #(
    parameter NUM_CH = 4
) (
    input wire ref_clk,
    input wire resetn,
    input wire [NUM_CH-1:0] sync_bit_error,
    input wire [NUM_CH-1:0] ebit_strobe,
    input wire [NUM_CH-1:0] ebit_value,
    input wire [NUM_CH-1:0] fas_sync_lost,
    input wire [NUM_CH-1:0] crc_mf_sync_lost,
    input wire [NUM_CH-1:0] cas_mf_sync_lost,
    input wire [`E1BC_ADDR_W-1:0] cpu_addr,
    input wire cpu_rd,
    output reg [`E1BC_BYTE_W-1:0] cpu_rdata_reg,
    output reg cpu_rvalid_reg,
    output reg cpu_unmapped_reg
);

    // decoded channel and register offset of the current access;
    // the channel nibble is widened before the range check so that the
    // compare against NUM_CH is done at full width
    wire [`E1BC_CH_MSB-`E1BC_CH_LSB:0] addr_ch;
    wire [`E1BC_OFS_W-1:0] addr_ofs;
    wire ch_in_range;

    assign addr_ch = cpu_addr[`E1BC_CH_MSB:`E1BC_CH_LSB];
    assign addr_ofs = cpu_addr[`E1BC_OFS_MSB:`E1BC_OFS_LSB];
    assign ch_in_range = ({28'h0000000, addr_ch} < NUM_CH);

    // one-hot read selects, shared by every channel; decoding the offset
    // once and qualifying it per channel keeps the decoder out of the loop
    reg sel_sync_high;
    reg sel_sync_low;
    reg sel_feb_high;
    reg sel_feb_low;
    reg sel_any;

    always @* begin
        sel_sync_high = 1'b0;
        sel_sync_low = 1'b0;
        sel_feb_high = 1'b0;
        sel_feb_low = 1'b0;
        if (addr_ofs == `E1BC_SYNC_BIT_ERROR_COUNT_HIGH) begin
            sel_sync_high = 1'b1;
        end else if (addr_ofs == `E1BC_SYNC_BIT_ERROR_COUNT_LOW) begin
            sel_sync_low = 1'b1;
        end else if (addr_ofs == `E1BC_FAR_END_BLOCK_ERROR_COUNT_HIGH) begin
            sel_feb_high = 1'b1;
        end else if (addr_ofs == `E1BC_FAR_END_BLOCK_ERROR_COUNT_LOW) begin
            sel_feb_low = 1'b1;
        end
        // only a known offset on an existing channel counts as a hit
        sel_any = ch_in_range & (sel_sync_high | sel_sync_low | sel_feb_high | sel_feb_low);
    end

    // per-channel counter state, flattened for the read mux;
    // instance outputs land in flat vectors and are sliced per channel,
    // since plain verilog has no array ports to carry them
    wire [NUM_CH*`E1BC_CNT_W-1:0] sync_live_flat;
    wire [NUM_CH*`E1BC_BYTE_W-1:0] sync_hold_flat;
    wire [NUM_CH-1:0] sync_hold_valid;
    wire [NUM_CH*`E1BC_CNT_W-1:0] feb_live_flat;
    wire [NUM_CH*`E1BC_BYTE_W-1:0] feb_hold_flat;
    wire [NUM_CH-1:0] feb_hold_valid;
    wire [NUM_CH-1:0] feb_inc;
    wire [NUM_CH-1:0] ch_hit;

    // one counter pair per channel
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
            // a read only touches the channel it addresses
            assign ch_hit[gi] = cpu_rd & ch_in_range & (addr_ch == gi);

            // far-end error: a zero e-bit, but only while fas and crc-4 sync hold;
            // cas multiframe loss is deliberately not part of the gate;
            // a one e-bit marks a good far-end block and is dropped here
            assign feb_inc[gi] = ebit_strobe[gi] & ~ebit_value[gi]
                & ~fas_sync_lost[gi] & ~crc_mf_sync_lost[gi];

            // sync-bit errors count with no gate of their own
            e1bc_err_counter u_sync (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .inc(sync_bit_error[gi]),
                .rd_high(ch_hit[gi] & sel_sync_high),
                .rd_low(ch_hit[gi] & sel_sync_low),
                .live_count(sync_live_flat[gi*`E1BC_CNT_W +: `E1BC_CNT_W]),
                .low_hold(sync_hold_flat[gi*`E1BC_BYTE_W +: `E1BC_BYTE_W]),
                .hold_valid(sync_hold_valid[gi])
            );

            // far-end counter sees only the gated event
            e1bc_err_counter u_feb (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .inc(feb_inc[gi]),
                .rd_high(ch_hit[gi] & sel_feb_high),
                .rd_low(ch_hit[gi] & sel_feb_low),
                .live_count(feb_live_flat[gi*`E1BC_CNT_W +: `E1BC_CNT_W]),
                .low_hold(feb_hold_flat[gi*`E1BC_BYTE_W +: `E1BC_BYTE_W]),
                .hold_valid(feb_hold_valid[gi])
            );
        end
    endgenerate

    // pick the addressed channel's counter state; an address past the
    // last channel matches no entry and leaves the zero defaults, which
    // sel_any masks out anyway
    reg [`E1BC_CNT_W-1:0] sync_live_sel;
    reg [`E1BC_BYTE_W-1:0] sync_hold_sel;
    reg sync_hold_valid_sel;
    reg [`E1BC_CNT_W-1:0] feb_live_sel;
    reg [`E1BC_BYTE_W-1:0] feb_hold_sel;
    reg feb_hold_valid_sel;
    // loop index for the channel mux, fixed bounds only
    integer ci;

    always @* begin
        sync_live_sel = `E1BC_CNT_RESET;
        sync_hold_sel = `E1BC_BYTE_RESET;
        sync_hold_valid_sel = 1'b0;
        feb_live_sel = `E1BC_CNT_RESET;
        feb_hold_sel = `E1BC_BYTE_RESET;
        feb_hold_valid_sel = 1'b0;
        for (ci = 0; ci < NUM_CH; ci = ci + 1) begin
            if (addr_ch == ci[`E1BC_CH_MSB-`E1BC_CH_LSB:0]) begin
                sync_live_sel = sync_live_flat[ci*`E1BC_CNT_W +: `E1BC_CNT_W];
                sync_hold_sel = sync_hold_flat[ci*`E1BC_BYTE_W +: `E1BC_BYTE_W];
                sync_hold_valid_sel = sync_hold_valid[ci];
                feb_live_sel = feb_live_flat[ci*`E1BC_CNT_W +: `E1BC_CNT_W];
                feb_hold_sel = feb_hold_flat[ci*`E1BC_BYTE_W +: `E1BC_BYTE_W];
                feb_hold_valid_sel = feb_hold_valid[ci];
            end
        end
    end

    // read data: a low byte comes from the snapshot when a high read
    // preceded it, otherwise straight from the live counter;
    // clear effects land at the same edge that captures the data
    reg [`E1BC_BYTE_W-1:0] rdata_next;

    always @* begin
        rdata_next = `E1BC_UNMAPPED_DATA;
        if (!sel_any) begin
            rdata_next = `E1BC_UNMAPPED_DATA;
        end else if (sel_sync_high) begin
            rdata_next = sync_live_sel[`E1BC_HI_MSB:`E1BC_HI_LSB];
        end else if (sel_sync_low) begin
            rdata_next = sync_hold_valid_sel ? sync_hold_sel
                : sync_live_sel[`E1BC_LO_MSB:`E1BC_LO_LSB];
        end else if (sel_feb_high) begin
            rdata_next = feb_live_sel[`E1BC_HI_MSB:`E1BC_HI_LSB];
        end else begin
            rdata_next = feb_hold_valid_sel ? feb_hold_sel
                : feb_live_sel[`E1BC_LO_MSB:`E1BC_LO_LSB];
        end
    end

    // registered answer, one cycle after the strobe; data holds until the next read
    // rvalid pulses for every read, mapped or not, so the host never waits
    // on an unmapped access; the flag tells it the byte is not a count
    always @(posedge ref_clk) begin
        if (!resetn) begin
            cpu_rdata_reg <= `E1BC_BYTE_RESET;
            cpu_rvalid_reg <= 1'b0;
            cpu_unmapped_reg <= 1'b0;
        end else begin
            cpu_rvalid_reg <= cpu_rd;
            if (cpu_rd) begin
                cpu_rdata_reg <= rdata_next;
                cpu_unmapped_reg <= ~sel_any;
            end
        end
    end

endmodule

`default_nettype wire

// ---- e1bc_rx_properties.sv ----
/*
 * concurrent checks on the counter bank's host port and channel 0 counts.
 * assumes only the top module's ports, attached by the bind at the foot.
 */
`timescale 1ns/10ps
`default_nettype none
module e1bc_rx_properties #(
    parameter NUM_CH = 4
) (
    input wire ref_clk,
    input wire resetn,
    input wire [NUM_CH-1:0] sync_bit_error,
    input wire [NUM_CH-1:0] ebit_strobe,
    input wire [NUM_CH-1:0] ebit_value,
    input wire [NUM_CH-1:0] fas_sync_lost,
    input wire [NUM_CH-1:0] crc_mf_sync_lost,
    input wire [15:0] cpu_addr,
    input wire cpu_rd,
    input wire [7:0] cpu_rdata_reg,
    input wire cpu_rvalid_reg,
    input wire cpu_unmapped_reg
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // channel 0 reads with no event in the same cycle, so no count slips in
    wire sb = sync_bit_error[0];
    wire fe = ebit_strobe[0] && !ebit_value[0];
    wire lost = fas_sync_lost[0] || crc_mf_sync_lost[0];
    wire sh0 = cpu_rd && cpu_addr == 16'h0905 && !sb;
    wire sl0 = cpu_rd && cpu_addr == 16'h0906 && !sb;
    wire fh0 = cpu_rd && cpu_addr == 16'h0907 && !fe;
    wire fl0 = cpu_rd && cpu_addr == 16'h0908 && !fe;
    wire [11:0] ofs = cpu_addr[11:0];
    wire mapped = cpu_addr[15:12] < NUM_CH && ofs >= 12'h905 && ofs <= 12'h908;

    a_read_answers: assert property (cpu_rd |=> cpu_rvalid_reg)
        else $error("read not answered next cycle");
    a_no_stray_answer: assert property (!cpu_rd |=> !cpu_rvalid_reg)
        else $error("answer without a read");
    a_unmapped_flag: assert property (cpu_rd && !mapped |=> cpu_unmapped_reg && cpu_rdata_reg == 8'h00)
        else $error("unmapped read not flagged as zero");
    a_mapped_flag: assert property (cpu_rd && mapped |=> !cpu_unmapped_reg)
        else $error("mapped read flagged");
    a_sync_clears: assert property (sh0 ##1 sl0 ##1 sl0 |=> cpu_rdata_reg == 8'h00)
        else $error("sync count not cleared by ordered read");
    a_sync_counts: assert property (sh0 ##1 sl0 ##1 (sb && !cpu_rd) ##1 sl0 |=> cpu_rdata_reg == 8'h01)
        else $error("one sync error not counted once");
    a_febe_counts: assert property (fh0 ##1 fl0 ##1 (fe && !lost && !cpu_rd) ##1 fl0 |=> cpu_rdata_reg == 8'h01)
        else $error("zero e-bit not counted once");
    a_febe_holds: assert property (fh0 ##1 fl0 ##1 (fe && lost && !cpu_rd) ##1 fl0 |=> cpu_rdata_reg == 8'h00)
        else $error("far-end count moved during sync loss");
endmodule
bind e1bc_rx_block_error_counters e1bc_rx_properties #(.NUM_CH(NUM_CH)) u_props (
    .ref_clk(ref_clk), .resetn(resetn), .sync_bit_error(sync_bit_error), .ebit_strobe(ebit_strobe),
    .ebit_value(ebit_value), .fas_sync_lost(fas_sync_lost), .crc_mf_sync_lost(crc_mf_sync_lost),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_rdata_reg(cpu_rdata_reg),
    .cpu_rvalid_reg(cpu_rvalid_reg), .cpu_unmapped_reg(cpu_unmapped_reg));
`default_nettype wire

// ---- e1bc_host_model.sv ----
/*
 * host processor model issuing one-cycle read strobes on the counter port.
 * assumes its caller calls req just after a rising edge of ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module e1bc_host_model (
    input wire logic ref_clk,
    output var logic [15:0] cpu_addr,
    output var logic cpu_rd
);
    initial begin
        cpu_addr = 16'h0000;
        cpu_rd = 1'b0;
    end
    // callers may read a low byte with no high read before it; idle address is scrambled,
    // so a decoder that ignores the strobe cannot ride on a stale address
    task req(input logic r, input logic [15:0] a);
        cpu_rd <= r;
        cpu_addr <= r ? a : ~cpu_addr;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/*
 * self-checking bench for the receive block error counter bank.
 * assumes the design's default of four channels; events hit all channels.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] sync_bit_error = 4'h0, ebit_strobe = 4'h0, ebit_value = 4'h0;
    logic [3:0] fas_sync_lost = 4'h0, crc_mf_sync_lost = 4'h0, cas_mf_sync_lost = 4'h0;
    logic lf = 1'b0, lc = 1'b0, lk = 1'b0, bval = 1'b0;
    wire [15:0] cpu_addr;
    wire cpu_rd;
    wire [7:0] cpu_rdata_reg;
    wire cpu_rvalid_reg, cpu_unmapped_reg;
    wire [9:0] obs = {cpu_rvalid_reg, cpu_unmapped_reg, cpu_rdata_reg};
    integer num_errors = 0, checks_done = 0, k;
    logic [15:0] a;
    logic [1:0] e;

    always #10 ref_clk = ~ref_clk;

    e1bc_host_model host (.ref_clk(ref_clk), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd));
    e1bc_rx_block_error_counters uut (
        .ref_clk(ref_clk), .resetn(resetn), .sync_bit_error(sync_bit_error), .ebit_strobe(ebit_strobe),
        .ebit_value(ebit_value), .fas_sync_lost(fas_sync_lost), .crc_mf_sync_lost(crc_mf_sync_lost),
        .cas_mf_sync_lost(cas_mf_sync_lost), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
        .cpu_rdata_reg(cpu_rdata_reg), .cpu_rvalid_reg(cpu_rvalid_reg), .cpu_unmapped_reg(cpu_unmapped_reg));

    // one cycle: read request plus framer events; obs then shows the previous read
    task go(input logic r, input logic [15:0] ad, input logic [1:0] ev);
        @(posedge ref_clk);
        host.req(r, ad);
        sync_bit_error <= {4{ev[0]}};
        ebit_strobe <= {4{ev[1]}};
        ebit_value <= {4{bval}};
        fas_sync_lost <= {4{lf}};
        crc_mf_sync_lost <= {4{lc}};
        cas_mf_sync_lost <= {4{lk}};
        #1;
    endtask
    task chk(input logic [9:0] seen, input logic [9:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            num_errors = num_errors + 1;
        end
    endtask
    task summarize;
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        // per counter: reset zero, clears, then one lone event counts once
        lk = 1'b1;
        for (k = 0; k < 2; k++) begin
            a = k ? 16'h0907 : 16'h0905;
            e = k ? 2'b10 : 2'b01;
            go(1'b1, a, 2'b00);
            go(1'b1, a + 16'h0001, 2'b00);
            chk(obs, 10'h200);
            go(1'b1, a + 16'h0001, 2'b00);
            chk(obs, 10'h200);
            go(1'b1, a, 2'b00);
            chk(obs, 10'h200);
            go(1'b1, a + 16'h0001, 2'b00);
            chk(obs, 10'h200);
            go(1'b0, 16'h0000, e);
            chk(obs, 10'h200);
            go(1'b1, a + 16'h0001, 2'b00);
            go(1'b0, 16'h0000, 2'b00);
            chk(obs, 10'h201);
        end
        // either sync loss freezes the far-end count
        for (k = 0; k < 2; k++) begin
            lf = !k;
            lc = k;
            go(1'b1, 16'h0907, 2'b00);
            go(1'b1, 16'h0908, 2'b00);
            go(1'b0, 16'h0000, 2'b10);
            go(1'b1, 16'h0908, 2'b00);
            go(1'b0, 16'h0000, 2'b00);
            chk(obs, 10'h200);
        end
        lf = 1'b0;
        lc = 1'b0;
        // 300 events carry into the high byte (channels 1 to 3 already hold one); e-bits of one never count
        repeat (300) go(1'b0, 16'h0000, 2'b11);
        bval = 1'b1;
        repeat (5) go(1'b0, 16'h0000, 2'b10);
        bval = 1'b0;
        // event in the clearing cycle must survive into the live count
        go(1'b1, 16'h2905, 2'b01);
        go(1'b1, 16'h2906, 2'b00);
        chk(obs, 10'h201);
        go(1'b1, 16'h2906, 2'b00);
        chk(obs, 10'h22D);
        go(1'b1, 16'h3907, 2'b00);
        chk(obs, 10'h201);
        go(1'b1, 16'h3908, 2'b00);
        chk(obs, 10'h201);
        go(1'b1, 16'h4907, 2'b00);
        chk(obs, 10'h22D);
        go(1'b1, 16'h0909, 2'b00);
        chk(obs, 10'h300);
        go(1'b0, 16'h0000, 2'b00);
        chk(obs, 10'h300);
        // mid-run reset: a loaded counter and the unmapped flag return to zero
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) go(1'b0, 16'h0000, 2'b00);
        @(posedge ref_clk);
        resetn <= 1'b1;
        go(1'b1, 16'h1905, 2'b00);
        chk(obs, 10'h000);
        go(1'b0, 16'h0000, 2'b00);
        chk(obs, 10'h200);
        summarize();
    end
endmodule
`default_nettype wire
